// File: design/liu_defines.svh
// Constants of the line interface interrupt, reset and configuration logic
// Summary of operation
// RQ1 - Pin mode: open-drain low, push-pull low, high
// RQ2 - Global disable bit gates every interrupt source
// RQ3 - Summary register holds one pending flag per channel
// RQ4 - Events latch per bit, each with mask bit
// RQ5 - Edge-select bit picks transition that latches event
// RQ6 - Reading channel status clears its pending flag
// RQ7 - Output idles only after all events acknowledged
// RQ8 - Thirteen sources; seven carry live and edge bits (code has fifteen per channel: seven in lat0, eight in lat1)
// RQ9 - Remaining events have latched and mask bits only
// RQ10 - Any reset register write resets within 1 us
// RQ11 - Host holds reset pin low 100 ns minimum
// RQ12 - Host waits 50 us after reset before access
// RQ13 - After reset drivers high-Z, registers at defaults
// RQ14 - Software reset keeps carrier-standard select bit
// RQ15 - Global writes hit both; local only own channel
// RQ16 - Broadcast bit copies local writes to other channel
// RQ17 - Host writes reserved bits with default values
// RQ18 - Reading latched status register clears its bits
// RQ19 - Output asserted for enabled, unmasked latched event
`ifndef LIU_DEFINES_SVH
`define LIU_DEFINES_SVH
// Global register addresses
`define LIU_A_ID 6'h00
`define LIU_A_RST 6'h01
`define LIU_A_GCF 6'h20
`define LIU_A_SUM 6'h21
// Local offsets; bit 5 of the address picks the channel
`define LIU_L_MASK0 5'h13
`define LIU_L_MASK1 5'h14
`define LIU_L_EDGE 5'h15
`define LIU_L_LIVE0 5'h16
`define LIU_L_LIVE1 5'h17
`define LIU_L_LAT0 5'h18
`define LIU_L_LAT1 5'h19
`define LIU_CH_BIT 5
// Global configuration fields and the loopback bit of LIVE1
`define LIU_GCF_PIN 1:0
`define LIU_GCF_GDIS 2
`define LIU_GCF_BCAST 3
`define LIU_GCF_CSS 4
`define LIU_GCF_MON 7:6
`define LIU_LIVE1_LOOP 5
// Reset values and reserved bits
`define LIU_GCF_RST 8'h00
`define LIU_MASK0_RST 8'h7F
`define LIU_MASK1_RST 8'hFF
`define LIU_EDGE_RST 8'h00
`define LIU_GCF_RSVD 8'h20
`define LIU_L0_RSVD 8'h80
// Timing
`define LIU_CLK_NS 50
`define LIU_SRST_NS 1000
`define LIU_SRST_CYC (`LIU_SRST_NS / `LIU_CLK_NS)
`define LIU_HWRST_NS 100
`define LIU_HWRST_CYC ((`LIU_HWRST_NS + `LIU_CLK_NS - 1) / `LIU_CLK_NS)
`define LIU_SETTLE_NS 50000
`define LIU_SETTLE_CYC ((`LIU_SETTLE_NS + `LIU_CLK_NS - 1) / `LIU_CLK_NS)
// Host controller registers and bits
`define LIU_H_ADDR 3'h0
`define LIU_H_DATA 3'h1
`define LIU_H_CTRL 3'h2
`define LIU_H_STAT 3'h3
`define LIU_H_MASK 3'h4
`define LIU_H_RDAT 3'h5
`define LIU_HC_WR 0
`define LIU_HC_RD 1
`define LIU_HC_HWRST 2
`endif

// File: design/liu_pkg.sv
// Types of the line interface interrupt, reset and configuration logic
`default_nettype none
package liu_pkg;
   typedef struct packed {
      logic [6:0] mask0;
      logic [7:0] mask1;
      logic [6:0] edge_sel;
      logic [6:0] lat0;
      logic [7:0] lat1;
      logic [6:0] prev0;
      logic pending;
   } liu_chan_st_t;
   typedef struct packed {
      logic [1:0] mon;
      logic css;
      logic bcast;
      logic gdis;
      logic [1:0] pin_mode;
      logic [7:0] rdata;
      logic int_o;
      logic int_oe_n;
      logic drv_hiz;
      logic [4:0] srst_cnt;
   } liu_dev_st_t;
   typedef enum logic [2:0] {h_idle, h_rst_low, h_settle, h_rd_req, h_rd_take} liu_host_state_t;
   typedef struct packed {
      liu_host_state_t state;
      logic [9:0] timer;
      logic rst_pin_n;
      logic [5:0] addr;
      logic [7:0] wdata;
      logic lk_wr;
      logic lk_rd;
      logic [5:0] cmd_addr;
      logic [7:0] cmd_data;
      logic [7:0] rd_val;
      logic [1:0] stat;
      logic [1:0] mask;
      logic [7:0] sw_rdata;
      logic irq;
   } liu_host_st_t;
endpackage
`default_nettype wire

// File: design/liu_link_if.sv
// Link between the host controller and the line interface register port
`timescale 1ns/1ps
`default_nettype none
interface liu_link_if;
   // Hardware reset pin
   logic rst_pin_n;
   // Register access
   logic [5:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   // Interrupt pin
   logic int_o;
   logic int_oe_n;
   logic int_line;
   // Pull-up while released
   assign int_line = int_oe_n ? 1'b1 : int_o;
   modport dev (input rst_pin_n, input addr, input wdata, input wr, input rd, output rdata,
      output int_o, output int_oe_n);
   modport host (output rst_pin_n, output addr, output wdata, output wr, output rd, input rdata,
      input int_line);
endinterface // liu_link_if
`default_nettype wire

// File: design/liu_chan_irq.sv
// Per-channel interrupt latching, masking and pending flag
`timescale 1ns/1ps
`default_nettype none
`include "liu_defines.svh"
module liu_chan_irq (
   // Clock, reset and enable
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   input wire logic clr,
   // Register strobes
   input wire logic wr_mask0,
   input wire logic wr_mask1,
   input wire logic wr_edge,
   input wire logic rd_lat0,
   input wire logic rd_lat1,
   input wire logic [7:0] wdata,
   // Event inputs
   input wire logic [6:0] live0,
   input wire logic [7:0] evt1,
   // Register contents and state
   output logic [6:0] mask0,
   output logic [7:0] mask1,
   output logic [6:0] edge_sel,
   output logic [6:0] lat0,
   output logic [7:0] lat1,
   output logic pending,
   output logic req
);
   localparam logic [7:0] M0_RST = `LIU_MASK0_RST;
   localparam logic [7:0] ES_RST = `LIU_EDGE_RST;
   liu_pkg::liu_chan_st_t st;
   liu_pkg::liu_chan_st_t next_st;
   logic [6:0] edge_hit;
   logic rd_any;
   logic new_set;
   logic remain;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_st = st;
      rd_any = rd_lat0 || rd_lat1;
      // Rising edge when select is 0, falling when 1
      edge_hit = (live0 & ~st.prev0 & ~st.edge_sel) | (~live0 & st.prev0 & st.edge_sel); // RQ5 RQ8
      next_st.prev0 = live0;
      next_st.lat0 = (st.lat0 & ~{7{rd_lat0}}) | edge_hit; // RQ4 RQ18
      next_st.lat1 = (st.lat1 & ~{8{rd_lat1}}) | evt1; // RQ4 RQ9 RQ18
      if (wr_mask0) begin
         next_st.mask0 = wdata[6:0];
      end
      if (wr_mask1) begin
         next_st.mask1 = wdata;
      end
      if (wr_edge) begin
         next_st.edge_sel = wdata[6:0];
      end
      new_set = |(edge_hit & ~st.mask0) || |(evt1 & ~st.mask1);
      remain = |(next_st.lat0 & ~next_st.mask0) || |(next_st.lat1 & ~next_st.mask1);
      next_st.pending = new_set || (st.pending && !rd_any) || (rd_any && remain); // RQ6 RQ7
      if (clr) begin
         next_st.mask0 = M0_RST[6:0];
         next_st.mask1 = `LIU_MASK1_RST;
         next_st.edge_sel = ES_RST[6:0];
         next_st.lat0 = 7'h00;
         next_st.lat1 = 8'h00;
         next_st.prev0 = 7'h00;
         next_st.pending = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st <= '{mask0: M0_RST[6:0], mask1: `LIU_MASK1_RST, edge_sel: ES_RST[6:0], default: '0};
      end else if (ce) begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign mask0 = st.mask0;
   assign mask1 = st.mask1;
   assign edge_sel = st.edge_sel;
   assign lat0 = st.lat0;
   assign lat1 = st.lat1;
   assign pending = st.pending;
   assign req = |(st.lat0 & ~st.mask0) || |(st.lat1 & ~st.mask1); // RQ19
endmodule // liu_chan_irq
`default_nettype wire

// File: design/liu_device.sv
// Device end: interrupt aggregation, reset handling and global configuration
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "liu_defines.svh"
module liu_device #(
   // Revision code, arbitrary value
   parameter logic [7:0] CHIP_REV = 8'h5A
) (
   // Clock, reset and enable
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   // Register and interrupt link
   liu_link_if.dev lk,
   // Live status per channel
   input wire logic [1:0][6:0] live_status_0,
   input wire logic [1:0] loopback_status,
   // Event pulses per channel
   input wire logic [1:0][7:0] event_pulse_1,
   // Global configuration
   output logic carrier_standard_select,
   output logic [1:0] monitor_channel_select,
   output logic line_drv_hiz
);
   localparam logic [7:0] GCF_RST = `LIU_GCF_RST;
   liu_pkg::liu_dev_st_t st;
   liu_pkg::liu_dev_st_t next_st;
   logic clr;
   logic ch;
   logic irq_on;
   logic [7:0] rd_val;
   logic [7:0] gcf_val;
   logic [1:0] pend;
   logic [1:0] req;
   logic [1:0][6:0] mask0;
   logic [1:0][7:0] mask1;
   logic [1:0][6:0] edge_sel;
   logic [1:0][6:0] lat0;
   logic [1:0][7:0] lat1;

   ////////////////////////////////////////////////////////////////////////////
   // Reset sources: pin low or soft reset in progress
   assign clr = (st.srst_cnt != 5'h00) || !lk.rst_pin_n; // RQ10 RQ13
   // Address bit picks the channel
   assign ch = lk.addr[`LIU_CH_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Channels
   for (genvar c = 0; c < 2; c++) begin : g_ch
      logic wsel;
      logic rsel;
      // Own half of the map, or either half in broadcast mode
      assign wsel = lk.wr && !clr && ((ch == 1'(c)) || st.bcast); // RQ15 RQ16
      assign rsel = lk.rd && !clr && (ch == 1'(c)); // RQ15
      liu_chan_irq u_ch (
         .clk_sys (clk_sys),
         .resetn (resetn),
         .ce (ce),
         .clr (clr),
         .wr_mask0 (wsel && (lk.addr[4:0] == `LIU_L_MASK0)),
         .wr_mask1 (wsel && (lk.addr[4:0] == `LIU_L_MASK1)),
         .wr_edge (wsel && (lk.addr[4:0] == `LIU_L_EDGE)),
         .rd_lat0 (rsel && (lk.addr[4:0] == `LIU_L_LAT0)),
         .rd_lat1 (rsel && (lk.addr[4:0] == `LIU_L_LAT1)),
         .wdata (lk.wdata),
         .live0 (live_status_0[c]),
         .evt1 (event_pulse_1[c]),
         .mask0 (mask0[c]),
         .mask1 (mask1[c]),
         .edge_sel (edge_sel[c]),
         .lat0 (lat0[c]),
         .lat1 (lat1[c]),
         .pending (pend[c]),
         .req (req[c])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read multiplexer
   always_comb begin
      gcf_val = 8'h00;
      gcf_val[`LIU_GCF_PIN] = st.pin_mode;
      gcf_val[`LIU_GCF_GDIS] = st.gdis;
      gcf_val[`LIU_GCF_BCAST] = st.bcast;
      gcf_val[`LIU_GCF_CSS] = st.css;
      gcf_val[`LIU_GCF_MON] = st.mon;
      rd_val = 8'h00;
      // Globals win over local decode
      if (lk.addr == `LIU_A_ID) begin
         rd_val = CHIP_REV;
      end else if (lk.addr == `LIU_A_GCF) begin
         rd_val = gcf_val;
      end else if (lk.addr == `LIU_A_SUM) begin
         rd_val = {6'h00, pend}; // RQ3
      end else begin
         case (lk.addr[4:0])
            `LIU_L_MASK0: begin
               rd_val = {1'b0, mask0[ch]};
            end
            `LIU_L_MASK1: begin
               rd_val = mask1[ch];
            end
            `LIU_L_EDGE: begin
               rd_val = {1'b0, edge_sel[ch]};
            end
            `LIU_L_LIVE0: begin
               rd_val = {1'b0, live_status_0[ch]};
            end
            `LIU_L_LIVE1: begin
               rd_val[`LIU_LIVE1_LOOP] = loopback_status[ch];
            end
            `LIU_L_LAT0: begin
               rd_val = {1'b0, lat0[ch]};
            end
            `LIU_L_LAT1: begin
               rd_val = lat1[ch];
            end
            default: begin
               rd_val = 8'h00;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_st = st;
      // Read data stands one cycle
      next_st.rdata = 8'h00;
      if (lk.rd && !clr) begin
         next_st.rdata = rd_val;
      end
      // Soft reset countdown
      if (st.srst_cnt != 5'h00) begin
         next_st.srst_cnt = st.srst_cnt - 5'h01;
      end
      if (lk.wr && !clr) begin
         // Any value written starts the soft reset
         if (lk.addr == `LIU_A_RST) begin
            next_st.srst_cnt = 5'(`LIU_SRST_CYC - 1); // RQ10
         end
         if (lk.addr == `LIU_A_GCF) begin
            next_st.pin_mode = lk.wdata[`LIU_GCF_PIN];
            next_st.gdis = lk.wdata[`LIU_GCF_GDIS];
            next_st.bcast = lk.wdata[`LIU_GCF_BCAST];
            next_st.css = lk.wdata[`LIU_GCF_CSS];
            next_st.mon = lk.wdata[`LIU_GCF_MON];
            next_st.drv_hiz = 1'b0;
         end
      end
      // Interrupt pin drive
      irq_on = !st.gdis && (|req); // RQ2 RQ19 RQ7
      if (st.pin_mode == 2'b01) begin
         next_st.int_o = !irq_on; // RQ1
         next_st.int_oe_n = 1'b0;
      end else if (st.pin_mode == 2'b10) begin
         next_st.int_o = irq_on; // RQ1
         next_st.int_oe_n = 1'b0;
      end else begin
         // Open drain for 00 and 11
         next_st.int_o = 1'b0; // RQ1
         next_st.int_oe_n = !irq_on;
      end
      if (clr) begin
         next_st.pin_mode = GCF_RST[`LIU_GCF_PIN]; // RQ13
         next_st.gdis = GCF_RST[`LIU_GCF_GDIS];
         next_st.bcast = GCF_RST[`LIU_GCF_BCAST];
         next_st.mon = GCF_RST[`LIU_GCF_MON];
         next_st.int_o = 1'b0;
         next_st.int_oe_n = 1'b1;
         next_st.drv_hiz = 1'b1;
         next_st.rdata = 8'h00;
         // Soft reset leaves the carrier select alone
         if (!lk.rst_pin_n) begin
            next_st.css = GCF_RST[`LIU_GCF_CSS]; // RQ14
            next_st.srst_cnt = 5'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st <= '{int_oe_n: 1'b1, drv_hiz: 1'b1, default: '0};
         // Configuration at its reset value
         st.pin_mode <= GCF_RST[`LIU_GCF_PIN];
         st.gdis <= GCF_RST[`LIU_GCF_GDIS];
         st.bcast <= GCF_RST[`LIU_GCF_BCAST];
         st.css <= GCF_RST[`LIU_GCF_CSS];
         st.mon <= GCF_RST[`LIU_GCF_MON];
      end else if (ce) begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign lk.rdata = st.rdata;
   assign lk.int_o = st.int_o;
   assign lk.int_oe_n = st.int_oe_n;
   assign carrier_standard_select = st.css;
   assign monitor_channel_select = st.mon;
   assign line_drv_hiz = st.drv_hiz;
endmodule // liu_device
`default_nettype wire

// File: design/liu_host.sv
// Host end: register access sequencer and hardware reset driver
`timescale 1ns/1ps
`default_nettype none
`include "liu_defines.svh"
module liu_host (
   // Clock, reset and enable
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   // Software port
   input wire logic [2:0] sw_addr,
   input wire logic [7:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [7:0] sw_rdata,
   output logic host_irq,
   // Link to the device
   liu_link_if.host lk
);
   liu_pkg::liu_host_st_t st;
   liu_pkg::liu_host_st_t next_st;
   logic done;
   logic ctl;
   logic [7:0] rd_mux;

   // Reserved bits forced to their default of zero
   function automatic logic [7:0] fix_rsvd(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] m;
      m = 8'h00;
      if (a == `LIU_A_GCF) begin
         m = `LIU_GCF_RSVD;
      end else if ((a[4:0] == `LIU_L_MASK0) || (a[4:0] == `LIU_L_EDGE)) begin
         m = `LIU_L0_RSVD;
      end
      fix_rsvd = d & ~m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_st = st;
      next_st.lk_wr = 1'b0;
      next_st.lk_rd = 1'b0;
      done = 1'b0;
      ctl = sw_wr && (sw_addr == `LIU_H_CTRL);
      unique case (st.state)
         liu_pkg::h_idle: begin
            if (ctl && sw_wdata[`LIU_HC_WR]) begin
               next_st.lk_wr = 1'b1;
               next_st.addr = st.cmd_addr;
               next_st.wdata = fix_rsvd(st.cmd_addr, st.cmd_data); // RQ17
               next_st.timer = 10'h000;
               if (st.cmd_addr == `LIU_A_RST) begin
                  next_st.state = liu_pkg::h_settle; // RQ12
               end else begin
                  done = 1'b1;
               end
            end else if (ctl && sw_wdata[`LIU_HC_RD]) begin
               next_st.lk_rd = 1'b1;
               next_st.addr = st.cmd_addr;
               next_st.state = liu_pkg::h_rd_req;
            end else if (ctl && sw_wdata[`LIU_HC_HWRST]) begin
               next_st.rst_pin_n = 1'b0;
               next_st.timer = 10'h000;
               next_st.state = liu_pkg::h_rst_low;
            end
         end
         liu_pkg::h_rst_low: begin
            next_st.timer = st.timer + 10'h001;
            if (st.timer == 10'(`LIU_HWRST_CYC - 1)) begin
               next_st.rst_pin_n = 1'b1; // RQ11
               next_st.timer = 10'h000;
               next_st.state = liu_pkg::h_settle;
            end
         end
         liu_pkg::h_settle: begin
            next_st.timer = st.timer + 10'h001;
            if (st.timer == 10'(`LIU_SETTLE_CYC - 1)) begin
               next_st.state = liu_pkg::h_idle; // RQ12
               done = 1'b1;
            end
         end
         liu_pkg::h_rd_req: begin
            next_st.state = liu_pkg::h_rd_take;
         end
         liu_pkg::h_rd_take: begin
            next_st.rd_val = lk.rdata; // RQ3
            next_st.state = liu_pkg::h_idle;
            done = 1'b1;
         end
      endcase
      if (sw_wr && (sw_addr == `LIU_H_ADDR)) begin
         next_st.cmd_addr = sw_wdata[5:0];
      end
      if (sw_wr && (sw_addr == `LIU_H_DATA)) begin
         next_st.cmd_data = sw_wdata;
      end
      if (sw_wr && (sw_addr == `LIU_H_MASK)) begin
         next_st.mask = sw_wdata[1:0];
      end
      // Sticky events, set wins over write-one clear
      next_st.stat = (st.stat & ~((sw_wr && (sw_addr == `LIU_H_STAT)) ? sw_wdata[1:0] : 2'b00))
         | {!lk.int_line, done};
      next_st.irq = |(next_st.stat & next_st.mask);
      rd_mux = 8'h00;
      case (sw_addr)
         `LIU_H_ADDR: rd_mux = {2'b00, st.cmd_addr};
         `LIU_H_DATA: rd_mux = st.cmd_data;
         `LIU_H_CTRL: rd_mux = {7'h00, st.state != liu_pkg::h_idle};
         `LIU_H_STAT: rd_mux = {6'h00, st.stat};
         `LIU_H_MASK: rd_mux = {6'h00, st.mask};
         `LIU_H_RDAT: rd_mux = st.rd_val;
         default: rd_mux = 8'h00;
      endcase
      next_st.sw_rdata = sw_rd ? rd_mux : 8'h00;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st <= '{state: liu_pkg::h_settle, rst_pin_n: 1'b1, default: '0};
      end else if (ce) begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign sw_rdata = st.sw_rdata;
   assign host_irq = st.irq;
   assign lk.rst_pin_n = st.rst_pin_n;
   assign lk.addr = st.addr;
   assign lk.wdata = st.wdata;
   assign lk.wr = st.lk_wr;
   assign lk.rd = st.lk_rd;
endmodule // liu_host
`default_nettype wire

// File: testbench/liu_link_chk.sv
// Checker of the host-to-device register and interrupt link
`timescale 1ns/1ps
`default_nettype none
module liu_link_chk (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Link signals
   input wire logic rst_pin_n,
   input wire logic [5:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic int_o,
   input wire logic int_oe_n,
   input wire logic int_line
);
   logic [7:0] cfg;
   logic [7:0] cfg_q;
   logic [9:0] settle;
   logic held;
   logic idle_lvl;
   assign held = (cfg == cfg_q) && (settle == 10'h000);
   assign idle_lvl = (cfg[1:0] != 2'b10);
   ////////////////////////////////////////////////////////////////
   // Configuration mirror and host quiet time
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cfg <= 8'h00;
         cfg_q <= 8'h00;
         settle <= 10'h3E7;
      end else begin
         cfg_q <= cfg;
         if (!rst_pin_n) begin
            cfg <= 8'h00;
         end else if (wr && addr == 6'h01) begin
            cfg <= cfg & 8'h10;
         end else if (wr && addr == 6'h20) begin
            cfg <= wdata;
         end
         if (!rst_pin_n || (wr && addr == 6'h01)) begin
            settle <= 10'h3E7;
         end else if (settle != 10'h000) begin
            settle <= settle - 10'h001;
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   a_hwrst_width: assert property ($fell(rst_pin_n) |=> !rst_pin_n)
      else $error("reset pin low for one cycle only");
   a_settle_quiet: assert property (settle != 10'h000 |-> !(wr || rd))
      else $error("access during settle time");
   a_cfg_read: assert property (rd && addr == 6'h20 && settle == 10'h000 |=> rdata == $past(cfg))
      else $error("config read mismatch");
   a_sum_width: assert property (rd && addr == 6'h21 |=> rdata[7:2] == 6'h00)
      else $error("summary upper bits set");
   a_od_drive: assert property (held && cfg[0] == cfg[1] |-> int_o == 1'b0)
      else $error("open drain pin driven high");
   a_pp_drive: assert property (held && cfg[0] != cfg[1] |-> !int_oe_n)
      else $error("push-pull pin not driven");
   a_gdis_quiet: assert property (held && cfg[2] |-> int_line == idle_lvl)
      else $error("pin active while disabled");
   a_srst_quiet: assert property (wr && addr == 6'h01 |-> ##3 int_oe_n [*8])
      else $error("pin driven during soft reset");
   a_rsvd_zero: assert property (wr |-> !(addr == 6'h20 && wdata[5])
      && !(addr[4:0] inside {5'h13, 5'h15} && wdata[7]))
      else $error("reserved bit written as one");
endmodule // liu_link_chk
`default_nettype wire

// File: testbench/tb.sv
// Testbench joining host and device ends over the link
`timescale 1ns/1ps
`default_nettype none
module tb;
   // Revision code, arbitrary value
   localparam logic [7:0] REV = 8'hC3;
   localparam logic [5:0] RA [10] = '{6'h00, 6'h13, 6'h14, 6'h15, 6'h20, 6'h21, 6'h33, 6'h34, 6'h35, 6'h0A};
   localparam logic [7:0] RE [10] = '{REV, 8'h7F, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h7F, 8'hFF, 8'h00, 8'h00};
   logic clk_sys, resetn, ce, sw_wr, sw_rd, host_irq, css, hiz;
   logic [2:0] sw_addr;
   logic [7:0] sw_wdata, sw_rdata, ev;
   logic [1:0][6:0] live;
   logic [1:0][7:0] evt;
   logic [1:0] loopb, mon, mm;
   int error_cnt, cmp_count;
   liu_link_if lk();
   liu_host liu_host_inst (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
      .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .host_irq(host_irq), .lk(lk));
   liu_device #(.CHIP_REV(REV)) liu_device_inst (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .lk(lk),
      .live_status_0(live), .loopback_status(loopb), .event_pulse_1(evt), .carrier_standard_select(css),
      .monitor_channel_select(mon), .line_drv_hiz(hiz));
   liu_link_chk liu_link_chk_inst (.clk_sys(clk_sys), .resetn(resetn), .rst_pin_n(lk.rst_pin_n), .addr(lk.addr),
      .wdata(lk.wdata), .wr(lk.wr), .rd(lk.rd), .rdata(lk.rdata), .int_o(lk.int_o), .int_oe_n(lk.int_oe_n),
      .int_line(lk.int_line));
   ////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   function automatic logic [7:0] global_config(input logic [1:0] m, input logic c, input logic b, input logic g,
      input logic [1:0] p);
      return {m, 1'b1, c, b, g, p};
   endfunction
   function automatic logic act(input logic [1:0] p);
      return p == 2'b10;
   endfunction
   task automatic sw_write(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge clk_sys);
      sw_wr <= 1'b0;
   endtask
   task automatic sw_read(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge clk_sys);
      sw_rd <= 1'b0;
      #1;
      d = sw_rdata;
   endtask
   task automatic wait_idle();
      logic [7:0] s;
      for (int i = 0; i < 1500; i++) begin
         sw_read(3'h2, s);
         if (s[0] === 1'b0) return;
      end
      error_cnt++;
      finish_test();
   endtask
   task automatic dev_wr(input logic [5:0] a, input logic [7:0] d);
      sw_write(3'h0, {2'b00, a});
      sw_write(3'h1, d);
      sw_write(3'h2, 8'h01);
      wait_idle();
   endtask
   task automatic dev_rd(input logic [5:0] a, output logic [7:0] d);
      sw_write(3'h0, {2'b00, a});
      sw_write(3'h2, 8'h02);
      wait_idle();
      sw_read(3'h5, d);
   endtask
   task automatic dev_chk(input logic [5:0] a, input logic [7:0] e);
      logic [7:0] d;
      dev_rd(a, d);
      chk8(d, e);
   endtask
   task automatic pulse(input logic [1:0] ch, input logic [7:0] v);
      @(posedge clk_sys);
      evt[0] <= ch[0] ? v : 8'h00;
      evt[1] <= ch[1] ? v : 8'h00;
      @(posedge clk_sys);
      evt <= 16'h0000;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial begin
      {resetn, sw_wr, sw_rd, sw_addr, sw_wdata, live, loopb, evt} = '0;
      ce = 1'b1;
      error_cnt = 0;
      cmp_count = 0;
      void'($urandom(32'hF881));
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      chk1(hiz, 1'b1);
      wait_idle();
      for (int i = 0; i < 10; i++) dev_chk(RA[i], RE[i]);
      mm = 2'($urandom_range(3));
      dev_wr(6'h20, global_config(mm, 1'b1, 1'b1, 1'b0, 2'b00));
      chk1(css, 1'b1);
      chk8({6'h00, mon}, {6'h00, mm});
      dev_wr(6'h14, 8'h00);
      dev_chk(6'h34, 8'h00);
      dev_wr(6'h20, global_config(mm, 1'b1, 1'b0, 1'b0, 2'b00));
      dev_wr(6'h13, 8'h80);
      dev_chk(6'h33, 8'h7F);
      ev = 8'($urandom_range(255, 1));
      pulse(2'b11, ev);
      chk1(lk.int_line, 1'b0);
      dev_chk(6'h21, 8'h03);
      dev_chk(6'h19, ev);
      chk1(lk.int_line, 1'b0);
      dev_chk(6'h21, 8'h02);
      dev_chk(6'h39, ev);
      dev_chk(6'h21, 8'h00);
      chk1(lk.int_line, 1'b1);
      dev_chk(6'h19, 8'h00);
      dev_wr(6'h14, 8'hFF);
      pulse(2'b01, ev);
      chk1(lk.int_line, 1'b1);
      dev_chk(6'h21, 8'h00);
      dev_chk(6'h19, ev);
      dev_wr(6'h14, 8'h00);
      @(posedge clk_sys);
      ce <= 1'b0;
      pulse(2'b01, ev);
      ce <= 1'b1;
      dev_chk(6'h19, 8'h00);
      for (int e = 0; e < 2; e++) begin
         dev_wr(6'h15, (e == 1) ? 8'hFF : 8'h80);
         for (int i = 0; i < 7; i++) begin
            @(posedge clk_sys);
            live[0][i] <= 1'b1;
            dev_chk(6'h16, 8'(8'h01 << i));
            dev_chk(6'h18, (e == 1) ? 8'h00 : 8'(8'h01 << i));
            @(posedge clk_sys);
            live[0][i] <= 1'b0;
            dev_chk(6'h18, (e == 1) ? 8'(8'h01 << i) : 8'h00);
         end
      end
      @(posedge clk_sys);
      loopb <= 2'b11;
      dev_chk(6'h17, 8'h20);
      for (int m = 0; m < 4; m++) begin
         dev_wr(6'h20, global_config(mm, 1'b1, 1'b0, 1'b1, 2'(m)));
         pulse(2'b01, ev);
         chk1(lk.int_line, !act(2'(m)));
         dev_wr(6'h20, global_config(mm, 1'b1, 1'b0, 1'b0, 2'(m)));
         chk1(lk.int_line, act(2'(m)));
         dev_chk(6'h19, ev);
         chk1(lk.int_line, !act(2'(m)));
      end
      sw_write(3'h3, 8'h03);
      sw_write(3'h4, 8'h01);
      dev_chk(6'h00, REV);
      chk1(host_irq, 1'b1);
      sw_write(3'h4, 8'h00);
      repeat (2) @(posedge clk_sys);
      chk1(host_irq, 1'b0);
      sw_write(3'h4, 8'h01);
      repeat (2) @(posedge clk_sys);
      chk1(host_irq, 1'b1);
      sw_write(3'h3, 8'h01);
      repeat (2) @(posedge clk_sys);
      chk1(host_irq, 1'b0);
      dev_wr(6'h01, 8'($urandom));
      chk1(hiz, 1'b1);
      chk1(css, 1'b1);
      dev_chk(6'h20, 8'h10);
      dev_chk(6'h14, 8'hFF);
      sw_write(3'h2, 8'h04);
      wait_idle();
      chk1(css, 1'b0);
      dev_chk(6'h20, 8'h00);
      finish_test();
   end
endmodule // tb
`default_nettype wire
